// *** scp_host_model.sv ***
/*
 Host controller model driving the serial configuration link.
 Assumes the bench calls send from its own process.
*/
`timescale 1ns/1ps
module scp_host_model (
   input  wire logic          inv_i,
   output scp_pkg::scp_link_t link_o
);
   initial link_o = 3'h4;
   // One word; sel low leaves chip select inactive
   task automatic send(input logic [7:0] w, input logic sel, input int h);
      link_o.clk = inv_i;
      #h link_o.cs_n = !sel;
      for (int i = 7; i >= 0; i--) begin
         link_o.din = w[i];
         #h link_o.clk = !inv_i;
         #h link_o.clk = inv_i;
      end
      link_o.cs_n = 1'b1;
      link_o.din = !w[0];
   endtask : send
endmodule : scp_host_model

// *** scp_pkg.sv ***
/*
 Package for the shared-pin serial configuration block: register offsets,
 field layouts, pin mode encodings, carriers and timing constants.
 Assumes nothing of its surroundings.
*/
package scp_pkg;
   // ==========================================================
   // Interface modes
   localparam logic [1:0] MODE_SERIAL   = 2'h3;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STAT   = 8'h04;
   localparam logic [7:0] OFS_IRQ    = 8'h08;
   localparam logic [7:0] OFS_MASK   = 8'h0C;
   localparam logic [7:0] OFS_CFG    = 8'h10;
   localparam logic [7:0] OFS_RESULT = 8'h14;
   // ==========================================================
   // Control fields
   localparam int CTRL_MODE_LO   = 0;
   localparam int CTRL_MODE_HI   = 1;
   localparam int CTRL_SRC_BIT   = 2;
   localparam int CTRL_CLKSRC    = 3;
   localparam int CTRL_INV_BIT   = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // ==========================================================
   // Status and interrupt bits
   localparam int EV_RDERR  = 0;
   localparam int EV_CFGWR  = 1;
   localparam int EV_W      = 2;
   // ==========================================================
   // Configuration word
   localparam int CFG_W = 8;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [3:0] CNT_W = 4'h8;
   // ==========================================================
   // Result width and shared pin bits
   localparam int RES_W   = 18;
   localparam int PIN_B14 = 14;
   localparam int PIN_B15 = 15;
   localparam int PIN_B16 = 16;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int ERR_PULSE_NS    = 15;
   localparam int ERR_PULSE_CYC   =
      (ERR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       inv;
      logic       clk_ext;
      logic       src_hw;
      logic [1:0] mode;
   } scp_ctrl_t;
   typedef struct packed {
      logic cs_n;
      logic clk;
      logic din;
   } scp_link_t;
endpackage : scp_pkg

// *** scp_shift.sv ***
/*
 Serial configuration shifter: captures bits MSB first on the active edge
 of the synchronised configuration clock while chip select is active.
 Assumes synchronised inputs on the system clock.
*/
`timescale 1ns/1ps
module scp_shift (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      en_i,
   input  wire logic                      inv_i,
   input  scp_pkg::scp_link_t             link_i,
   output logic [scp_pkg::CFG_W-1:0]      cfg_o,
   output logic                           done_o
);
   // ==========================================================
   // Edge detection
   logic                        clk_d;
   logic [scp_pkg::CFG_W-1:0]   sh;
   logic [3:0]                  cnt;
   wire  rise   = link_i.clk & ~clk_d;
   wire  fall   = ~link_i.clk & clk_d;
   wire  active = en_i & ~link_i.cs_n;
   wire  edge_s = inv_i ? fall : rise;
   wire  last   = (cnt == scp_pkg::CNT_W - 4'h1);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_d  <= 1'b0;
         sh     <= scp_pkg::CFG_RESET;
         cnt    <= 4'h0;
         cfg_o  <= scp_pkg::CFG_RESET;
         done_o <= 1'b0;
      end else begin
         clk_d  <= link_i.clk;
         done_o <= 1'b0;
         if (!active) begin
            cnt <= 4'h0;
         end else if (edge_s) begin
            sh <= {sh[scp_pkg::CFG_W-2:0], link_i.din};
            cnt <= last ? 4'h0 : cnt + 4'h1;
            if (last) begin
               cfg_o  <= {sh[scp_pkg::CFG_W-2:0], link_i.din};
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule : scp_shift

// *** scp_sync.sv ***
/*
 Two-flip-flop synchroniser for a bundle of asynchronous pin levels.
 Assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module scp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : scp_sync

// *** scp_top.sv ***
/*
 Shared-pin logic of a converter host interface: three pins carry result
 bits 14..16 in parallel modes or act as the serial configuration port,
 read error flag generation, and an APB register file with interrupts.
 Assumes APB master on MCLK_I; pins arrive asynchronously.
*/
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module scp_top (
   input  wire logic        MCLK_I,
   input  wire logic        RESET_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic        CFG_SERIAL_IN_I,
   input  wire logic        CFG_SERIAL_CLOCK_I,
   input  wire logic        CFG_CHIP_SELECT_N_I,
   input  wire logic        CONFIG_SOURCE_SELECT_I,
   input  wire logic        CLOCK_EDGE_INVERT_I,
   input  wire logic        HW_RANGE_I,
   input  wire logic        HW_OPMODE_I,
   input  wire logic        CONV_START_I,
   input  wire logic        READ_ACTIVE_I,
   input  wire logic        READ_DONE_I,
   input  wire logic [17:0] RESULT_I,
   output logic             PAR_DATA_BIT_FOURTEEN_O,
   output logic             PAR_DATA_BIT_FIFTEEN_O,
   output logic             PAR_DATA_BIT_SIXTEEN_O,
   output logic             PAR_BITS_OE_O,
   output logic             READ_ERROR_FLAG_O,
   output logic             RANGE_SEL_O,
   output logic             OPMODE_SEL_O,
   output logic             IRQ_O
);
   // ==========================================================
   // Pin synchronisers
   logic [7:0] pin_s;
   scp_sync #(.W(8)) u_sync (
      .clk_i (MCLK_I),
      .rst_i (RESET_I),
      .d_i   ({CFG_SERIAL_IN_I, CFG_SERIAL_CLOCK_I, CFG_CHIP_SELECT_N_I,
               CONFIG_SOURCE_SELECT_I, CLOCK_EDGE_INVERT_I,
               CONV_START_I, READ_ACTIVE_I, READ_DONE_I}),
      .q_o   (pin_s)
   );
   wire din_s   = pin_s[7];
   wire sclk_s  = pin_s[6];
   wire cs_n_s  = pin_s[5];
   wire src_s   = pin_s[4];
   wire inv_s   = pin_s[3];
   wire conv_s  = pin_s[2];
   wire ract_s  = pin_s[1];
   wire rdone_s = pin_s[0];
   // ==========================================================
   // Control register
   scp_pkg::scp_ctrl_t ctrl;
   logic [scp_pkg::EV_W-1:0] irq_stat;
   logic [scp_pkg::EV_W-1:0] irq_mask;
   wire serial_mode = (ctrl.mode == scp_pkg::MODE_SERIAL);
   wire src_hw      = src_s | ctrl.src_hw;
   wire port_en     = serial_mode & ~src_hw;
   wire inv_eff     = inv_s ^ ctrl.inv;
   // ==========================================================
   // Serial configuration shifter
   scp_pkg::scp_link_t link;
   logic [scp_pkg::CFG_W-1:0] cfg_word;
   logic cfg_done;
   assign link.cs_n = cs_n_s;
   assign link.clk  = sclk_s;
   assign link.din  = din_s;
   scp_shift u_shift (
      .clk_i  (MCLK_I),
      .rst_i  (RESET_I),
      .en_i   (port_en),
      .inv_i  (inv_eff),
      .link_i (link),
      .cfg_o  (cfg_word),
      .done_o (cfg_done)
   );
   // ==========================================================
   // Effective settings
   wire next_range  = port_en ? cfg_word[1]
                              : HW_RANGE_I;
   wire next_opmode = port_en ? cfg_word[0]
                              : HW_OPMODE_I;
   // ==========================================================
   // Read error detection
   logic       conv_d;
   logic       read_open;
   logic [1:0] err_cnt;
   wire conv_rise  = conv_s & ~conv_d;
   wire slave_mode = serial_mode & ctrl.clk_ext;
   wire rd_err_ev  = slave_mode & conv_rise & read_open;
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         conv_d    <= 1'b0;
         read_open <= 1'b0;
         err_cnt   <= 2'h0;
      end else begin
         conv_d <= conv_s;
         if (conv_rise | rdone_s) begin
            read_open <= 1'b0;
         end else if (ract_s) begin
            read_open <= 1'b1;
         end
         if (rd_err_ev) begin
            err_cnt <= 2'(scp_pkg::ERR_PULSE_CYC);
         end else if (err_cnt != 2'h0) begin
            err_cnt <= err_cnt - 2'h1;
         end
      end
   end
   // ==========================================================
   // Result latch and shared pins
   logic [scp_pkg::RES_W-1:0] result;
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         result                  <= '0;
         PAR_DATA_BIT_FOURTEEN_O <= 1'b0;
         PAR_DATA_BIT_FIFTEEN_O  <= 1'b0;
         PAR_DATA_BIT_SIXTEEN_O  <= 1'b0;
         PAR_BITS_OE_O           <= 1'b0;
         READ_ERROR_FLAG_O       <= 1'b0;
         RANGE_SEL_O             <= 1'b0;
         OPMODE_SEL_O            <= 1'b0;
      end else begin
         if (conv_rise & ~rd_err_ev) begin
            result <= RESULT_I;
         end else if (rd_err_ev) begin
            result <= '0;
         end
         PAR_BITS_OE_O           <= ~serial_mode;
         PAR_DATA_BIT_FOURTEEN_O <= ~serial_mode & result[scp_pkg::PIN_B14];
         PAR_DATA_BIT_FIFTEEN_O  <= ~serial_mode & result[scp_pkg::PIN_B15];
         PAR_DATA_BIT_SIXTEEN_O  <= ~serial_mode & result[scp_pkg::PIN_B16];
         READ_ERROR_FLAG_O       <= rd_err_ev | (err_cnt > 2'h1);
         RANGE_SEL_O             <= next_range;
         OPMODE_SEL_O            <= next_opmode;
      end
   end
   // ==========================================================
   // APB register file
   wire setup  = PSEL_I & ~PENABLE_I;
   wire access = PSEL_I & PENABLE_I & PREADY_O;
   wire wr     = access & PWRITE_I;
   wire hit    = (PADDR_I == scp_pkg::OFS_CTRL)
               | (PADDR_I == scp_pkg::OFS_STAT)
               | (PADDR_I == scp_pkg::OFS_IRQ)
               | (PADDR_I == scp_pkg::OFS_MASK)
               | (PADDR_I == scp_pkg::OFS_CFG)
               | (PADDR_I == scp_pkg::OFS_RESULT);
   wire [scp_pkg::EV_W-1:0] events = {cfg_done, rd_err_ev};
   logic [31:0] rdata;
   always_comb begin
      case (PADDR_I)
         scp_pkg::OFS_CTRL:   rdata = {27'h0, ctrl};
         scp_pkg::OFS_STAT:   rdata = {26'h0, port_en, src_hw, inv_eff,
                                       read_open, RANGE_SEL_O, OPMODE_SEL_O};
         scp_pkg::OFS_IRQ:    rdata = {30'h0, irq_stat};
         scp_pkg::OFS_MASK:   rdata = {30'h0, irq_mask};
         scp_pkg::OFS_CFG:    rdata = {24'h0, cfg_word};
         scp_pkg::OFS_RESULT: rdata = {14'h0, result};
         default:             rdata = 32'h0;
      endcase
   end
   always_ff @(posedge MCLK_I) begin
      if (RESET_I) begin
         ctrl      <= scp_pkg::CTRL_RESET;
         irq_mask  <= '0;
         irq_stat  <= '0;
         PRDATA_O  <= 32'h0;
         PREADY_O  <= 1'b0;
         PSLVERR_O <= 1'b0;
         IRQ_O     <= 1'b0;
      end else begin
         PREADY_O  <= setup;
         PSLVERR_O <= setup & ~hit;
         if (setup) begin
            PRDATA_O <= PWRITE_I ? 32'h0 : rdata;
         end
         if (wr & (PADDR_I == scp_pkg::OFS_CTRL)) begin
            ctrl <= PWDATA_I[scp_pkg::CTRL_INV_BIT:scp_pkg::CTRL_MODE_LO];
         end
         if (wr & (PADDR_I == scp_pkg::OFS_MASK)) begin
            irq_mask <= PWDATA_I[scp_pkg::EV_W-1:0];
         end
         // Set wins over write-one-to-clear
         irq_stat <= (irq_stat & ~((wr & (PADDR_I == scp_pkg::OFS_IRQ))
                     ? PWDATA_I[scp_pkg::EV_W-1:0] : '0)) | events;
         IRQ_O <= |(irq_stat & irq_mask);
      end
   end
endmodule : scp_top

// *** scp_top_asserts.sv ***
/*
 Port checker for scp_top.
 Assumes it is bound into scp_top and clocked by MCLK_I.
*/
`timescale 1ns/1ps
module scp_top_asserts (
   input wire logic        MCLK_I,
   input wire logic        RESET_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        CONFIG_SOURCE_SELECT_I,
   input wire logic        HW_RANGE_I,
   input wire logic        PAR_DATA_BIT_FOURTEEN_O,
   input wire logic        PAR_DATA_BIT_FIFTEEN_O,
   input wire logic        PAR_DATA_BIT_SIXTEEN_O,
   input wire logic        PAR_BITS_OE_O,
   input wire logic        READ_ERROR_FLAG_O,
   input wire logic        RANGE_SEL_O,
   input wire logic        IRQ_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   a_reset_quiet: assert property (disable iff (1'b0)
      RESET_I |=> !IRQ_O && !READ_ERROR_FLAG_O && !PAR_BITS_OE_O)
      else $error("output active after reset");
   a_err_pulse_len: assert property (
      $rose(READ_ERROR_FLAG_O) |-> READ_ERROR_FLAG_O [*3] ##1
      !READ_ERROR_FLAG_O) else $error("error pulse length");
   a_par_pins_off: assert property (!PAR_BITS_OE_O |->
      !(PAR_DATA_BIT_FOURTEEN_O || PAR_DATA_BIT_FIFTEEN_O ||
      PAR_DATA_BIT_SIXTEEN_O)) else $error("shared pins not idle");
   a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=>
      PREADY_O) else $error("no ready after setup");
   a_ready_single: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready too long");
   a_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
      else $error("ready outside access");
   a_slverr_data: assert property (PSLVERR_O |-> PREADY_O &&
      PRDATA_O == 32'h0) else $error("error response malformed");
   a_hw_range: assert property (
      (CONFIG_SOURCE_SELECT_I && $stable(HW_RANGE_I)) [*5] |=>
      RANGE_SEL_O == HW_RANGE_I) else $error("hardware range ignored");
   c_err: cover property ($rose(READ_ERROR_FLAG_O));
   c_slverr: cover property (PSLVERR_O);
   c_irq: cover property ($rose(IRQ_O));
endmodule : scp_top_asserts
bind scp_top scp_top_asserts chk_i (.*);

// *** scp_top_tb_top.sv ***
/*
 Self-checking bench for scp_top with a host link model.
 Assumes scp_pkg, scp_host_model and the checker are compiled first.
*/
`timescale 1ns/1ps
module scp_top_tb_top;
   logic        MCLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I;
   logic [7:0]  PADDR_I;
   logic [31:0] PWDATA_I, PRDATA_O, q;
   logic [17:0] RESULT_I;
   logic        PREADY_O, PSLVERR_O, CONFIG_SOURCE_SELECT_I, e;
   logic        CLOCK_EDGE_INVERT_I, HW_RANGE_I, HW_OPMODE_I, CONV_START_I;
   logic        READ_ACTIVE_I, READ_DONE_I, PAR_DATA_BIT_FOURTEEN_O;
   logic        PAR_DATA_BIT_FIFTEEN_O, PAR_DATA_BIT_SIXTEEN_O, IRQ_O;
   logic        PAR_BITS_OE_O, READ_ERROR_FLAG_O, RANGE_SEL_O, OPMODE_SEL_O;
   scp_pkg::scp_link_t link;
   int          fail_count = 0;
   int          checks = 0;
   wire logic [31:0] pins = {28'h0, PAR_BITS_OE_O, PAR_DATA_BIT_SIXTEEN_O,
                             PAR_DATA_BIT_FIFTEEN_O, PAR_DATA_BIT_FOURTEEN_O};
   scp_top dut (.*, .CFG_SERIAL_IN_I(link.din), .CFG_SERIAL_CLOCK_I(link.clk),
                .CFG_CHIP_SELECT_N_I(link.cs_n));
   scp_host_model host (.inv_i(CLOCK_EDGE_INVERT_I), .link_o(link));
   initial begin
      MCLK_I = 1'b0;
      forever #2.5 MCLK_I = ~MCLK_I;
   end
   initial begin
      #100000 fail_count++;
      finish_test();
   end
   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [31:0] x, g);
      checks++;
      if (g !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge MCLK_I);
   endtask : wt
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      PSEL_I <= 1'b1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge MCLK_I) PENABLE_I <= 1'b1;
      do begin
         @(posedge MCLK_I);
      end while (PREADY_O !== 1'b1);
      q = PRDATA_O;
      e = PSLVERR_O;
      PSEL_I <= 1'b0;
      PENABLE_I <= 1'b0;
      wt(1);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask : rd
   task automatic conv(input logic act, dn, input logic [31:0] x);
      int n = 0;
      READ_ACTIVE_I <= act;
      wt(5);
      READ_DONE_I <= dn;
      READ_ACTIVE_I <= act & !dn;
      wt(5);
      CONV_START_I <= 1'b1;
      repeat (20) begin
         @(posedge MCLK_I);
         if (READ_ERROR_FLAG_O === 1'b1) n++;
      end
      CONV_START_I <= 1'b0;
      READ_DONE_I <= 1'b0;
      READ_ACTIVE_I <= 1'b0;
      wt(5);
      chk("error pulse cycles", x, n);
   endtask : conv
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // ==========================================================
   // Tests
   initial begin
      {PSEL_I, PENABLE_I, PWRITE_I, CONV_START_I, READ_ACTIVE_I} = '0;
      {READ_DONE_I, CONFIG_SOURCE_SELECT_I, CLOCK_EDGE_INVERT_I} = '0;
      {HW_RANGE_I, HW_OPMODE_I, PADDR_I, PWDATA_I, RESULT_I} = '0;
      RESET_I = 1'b1;
      wt(5);
      RESET_I <= 1'b0;
      rd(scp_pkg::OFS_CTRL, 32'(scp_pkg::CTRL_RESET), "ctrl");
      rd(scp_pkg::OFS_CFG, 32'(scp_pkg::CFG_RESET), "cfg");
      rd(8'h18, 32'h0, "unmapped");
      chk("unmapped error", 32'h1, e);
      $display("test reset finished");
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, scp_pkg::OFS_CTRL, m);
         RESULT_I <= 18'(m + 3) << 14;
         conv(1'b0, 1'b0, 32'h0);
         chk("shared pins", 32'(m + 11), pins);
      end
      apb(1'b1, scp_pkg::OFS_CTRL, 32'h3);
      apb(1'b1, scp_pkg::OFS_MASK, 32'h3);
      chk("shared pins", 32'h0, pins);
      $display("test pins finished");
      host.send(8'hA6, 1'b1, 24);
      wt(10);
      rd(scp_pkg::OFS_CFG, 32'hA6, "cfg");
      chk("settings", 32'h2, {RANGE_SEL_O, OPMODE_SEL_O});
      chk("irq line", 32'h1, IRQ_O);
      apb(1'b1, scp_pkg::OFS_IRQ, 32'h2);
      wt(1);
      chk("irq line", 32'h0, IRQ_O);
      CLOCK_EDGE_INVERT_I <= 1'b1;
      wt(4);
      host.send(8'h59, 1'b1, 24);
      wt(10);
      rd(scp_pkg::OFS_CFG, 32'h59, "cfg");
      chk("settings", 32'h1, {RANGE_SEL_O, OPMODE_SEL_O});
      apb(1'b1, scp_pkg::OFS_IRQ, 32'h2);
      host.send(8'hFF, 1'b0, 24);
      wt(10);
      rd(scp_pkg::OFS_CFG, 32'h59, "cfg");
      rd(scp_pkg::OFS_IRQ, 32'h0, "irq");
      $display("test serial finished");
      CONFIG_SOURCE_SELECT_I <= 1'b1;
      HW_RANGE_I <= 1'b1;
      HW_OPMODE_I <= 1'b1;
      wt(8);
      chk("settings", 32'h3, {RANGE_SEL_O, OPMODE_SEL_O});
      host.send(8'h00, 1'b1, 24);
      wt(10);
      rd(scp_pkg::OFS_CFG, 32'h59, "cfg");
      CONFIG_SOURCE_SELECT_I <= 1'b0;
      $display("test hardware finished");
      conv(1'b1, 1'b0, 32'h0);
      apb(1'b1, scp_pkg::OFS_CTRL, 32'hB);
      conv(1'b1, 1'b1, 32'h0);
      conv(1'b1, 1'b0, 32'h3);
      rd(scp_pkg::OFS_RESULT, 32'h0, "result");
      chk("irq line", 32'h1, IRQ_O);
      apb(1'b1, scp_pkg::OFS_MASK, 32'h0);
      wt(1);
      chk("irq line", 32'h0, IRQ_O);
      apb(1'b1, scp_pkg::OFS_IRQ, 32'h1);
      rd(scp_pkg::OFS_IRQ, 32'h0, "irq");
      $display("test read error finished");
      finish_test();
   end
endmodule : scp_top_tb_top
